// ===== rtl/clock_timer_pkg.sv
// Constants for the clock timer with its three periodic interrupts
package clock_timer_pkg;

	// Bus widths
	localparam int ADR_W = 12;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_STAGE   = 8'he4;
	localparam logic [7:0] IDX_ENABLE  = 8'heb;
	localparam logic [7:0] IDX_FLAG    = 8'hef;
	localparam logic [7:0] IDX_CONTROL = 8'hf9;

	// Word index field of the byte address
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 9;

	// Counter layout
	localparam int CNT_W     = 7;
	localparam int STAGE_LSB = 3;
	localparam int STAGE_MSB = 6;

	// Interrupt channels: 32 Hz, 8 Hz, 2 Hz
	localparam int NUM_IRQ = 3;
	localparam int F_32HZ  = 0;
	localparam int F_8HZ   = 1;
	localparam int F_2HZ   = 2;

	// Counter stage whose falling edge fires each channel
	localparam int IRQ_TAP [0:NUM_IRQ-1] = '{2, 4, 6};

	// Control word field
	localparam int RESTART_BIT = 2;

	// Reset values and the count step
	localparam logic [CNT_W-1:0]   CNT_RST  = 7'h00;
	localparam logic [NUM_IRQ-1:0] EN_RST   = 3'h0;
	localparam logic [NUM_IRQ-1:0] FLAG_RST = 3'h0;
	localparam logic [DAT_W-1:0]   DAT_ZERO = 32'h0000_0000;
	localparam logic [CNT_W-1:0]   CNT_ONE  = 7'h01;

endpackage

// ===== rtl/clock_timer_interrupts.sv
// Clock timer: seven-bit tick counter, readable stages, three interrupts
`timescale 1ns/100ps

module clock_timer_interrupts
	import clock_timer_pkg::*;
(
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Tick from the frequency divider, one cycle per 1/256 s
	input  wire logic             tick_256hz_i,
	// Wishbone slave
	input  wire logic [ADR_W-1:0] adr_i,
	input  wire logic [DAT_W-1:0] dat_i,
	input  wire logic [SEL_W-1:0] sel_i,
	input  wire logic             we_i,
	input  wire logic             cyc_i,
	input  wire logic             stb_i,
	output logic      [DAT_W-1:0] dat_o,
	output logic                  ack_o,
	// Interrupt request toward the processor
	output logic                  irq_o
);

	logic [CNT_W-1:0]   count;
	logic [CNT_W-1:0]   next_count;
	logic [NUM_IRQ-1:0] enables;
	logic [NUM_IRQ-1:0] flags;
	logic [NUM_IRQ-1:0] next_flags;
	logic [NUM_IRQ-1:0] flag_set;
	logic [NUM_IRQ-1:0] flag_clr;
	logic [7:0]         word_idx;
	logic               in_range;
	logic               take;
	logic               wr_take;
	logic               rd_take;
	logic               hit_stage;
	logic               hit_enable;
	logic               hit_flag;
	logic               hit_control;
	logic               restart;

	// Bus decode
	// Only the low byte lane carries register data; other lanes read zero
	assign word_idx    = adr_i[IDX_MSB:IDX_LSB];
	assign in_range    = (adr_i[ADR_W-1:IDX_MSB+1] == '0);
	assign take        = cyc_i & stb_i & ~ack_o;
	assign wr_take     = take & we_i;
	assign rd_take     = take & ~we_i;
	assign hit_stage   = in_range & (word_idx == IDX_STAGE);
	assign hit_enable  = in_range & (word_idx == IDX_ENABLE);
	assign hit_flag    = in_range & (word_idx == IDX_FLAG);
	assign hit_control = in_range & (word_idx == IDX_CONTROL);

	assign restart = wr_take & hit_control & sel_i[0] & dat_i[RESTART_BIT];

	// Single-cycle ack; every address answers, unmapped ones with zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= take;
		end
	end

	// Bus writes move the count only through restart
	// A restart beats a tick in the same cycle; counting resumes on the next tick
	always_comb begin
		if (restart) begin
			next_count = CNT_RST;
		end else if (tick_256hz_i) begin
			next_count = count + CNT_ONE;
		end else begin
			next_count = count;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count <= CNT_RST;
		end else begin
			count <= next_count;
		end
	end

	// Falling edge detect per channel
	// Restart clearing the stages is not treated as a falling edge
	generate
		for (genvar i = 0; i < NUM_IRQ; i++) begin : g_edge
			assign flag_set[i] = tick_256hz_i & ~restart &
				count[IRQ_TAP[i]] & ~next_count[IRQ_TAP[i]];
		end
	endgenerate

	// Clear on read of the flag word
	assign flag_clr = (rd_take & hit_flag) ? {NUM_IRQ{1'b1}} : FLAG_RST;

	// Set wins over the read clear so an edge in the read cycle is kept
	assign next_flags = (flags & ~flag_clr) | flag_set;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags <= FLAG_RST;
		end else begin
			flags <= next_flags;
		end
	end

	// Enables written from the low byte lane
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enables <= EN_RST;
		end else if (wr_take & hit_enable & sel_i[0]) begin
			enables <= dat_i[NUM_IRQ-1:0];
		end
	end

	// Read data register
	// Stage word shows only the top four stages
	// Unused low-lane bits (7:4 of stage, 7:3 of enable and flag) and upper lanes read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= DAT_ZERO;
		end else if (rd_take) begin
			dat_o <= DAT_ZERO;
			// Stage bits in ascending period order
			if (hit_stage) begin
				dat_o[STAGE_MSB-STAGE_LSB:0] <= count[STAGE_MSB:STAGE_LSB];
			end
			if (hit_enable) begin
				dat_o[NUM_IRQ-1:0] <= enables;
			end
			if (hit_flag) begin
				dat_o[NUM_IRQ-1:0] <= flags;
			end
		end else begin
			dat_o <= DAT_ZERO;
		end
	end

	// Each enable gates its own flag
	assign irq_o = |(flags & enables);

	// Checks
	default clocking cb @(posedge clk_i);
	endclocking

	count_step_a: assert property (
		disable iff (rst_i)
		(tick_256hz_i && !restart) |=> (count == $past(count) + CNT_ONE))
		else $error("counter did not advance on tick");

	count_hold_a: assert property (
		disable iff (rst_i)
		(!tick_256hz_i && !restart) |=> $stable(count))
		else $error("counter moved without tick");

	count_wrap_a: assert property (
		disable iff (rst_i)
		(tick_256hz_i && !restart && count == 7'h7f) |=> (count == CNT_RST))
		else $error("counter did not wrap at seven bits");

	stage_read_a: assert property (
		disable iff (rst_i)
		(rd_take && hit_stage) |=>
			(ack_o && dat_o[3:0] == $past(count[STAGE_MSB:STAGE_LSB]) &&
			dat_o[DAT_W-1:4] == '0))
		else $error("stage word does not show top four stages");

	stage_write_a: assert property (
		disable iff (rst_i)
		(wr_take && hit_stage && !tick_256hz_i) |=> $stable(count))
		else $error("write to stage word altered the counter");

	reset_state_a: assert property (
		rst_i |=> (count == CNT_RST && enables == EN_RST && flags == FLAG_RST &&
			!irq_o && !ack_o))
		else $error("reset did not clear timer state");

	flag_edge_a: assert property (
		disable iff (rst_i)
		(tick_256hz_i && !restart && count[4:0] == 5'h1f) |=>
			flags[F_8HZ] && flags[F_32HZ])
		else $error("8 Hz falling edge did not set flags");

	flag_2hz_a: assert property (
		disable iff (rst_i)
		(tick_256hz_i && !restart && count == 7'h7f && !enables[F_2HZ]) |=>
			flags[F_2HZ])
		else $error("masked 2 Hz edge did not set flag");

	no_spurious_a: assert property (
		disable iff (rst_i)
		(!tick_256hz_i && !(rd_take && hit_flag)) |=> (flags == $past(flags)))
		else $error("flag changed without edge or read");

	enable_write_a: assert property (
		disable iff (rst_i)
		(wr_take && hit_enable && sel_i[0]) |=>
			(enables == $past(dat_i[NUM_IRQ-1:0])))
		else $error("enable word did not take written value");

	enable_read_a: assert property (
		disable iff (rst_i)
		(rd_take && hit_enable) |=> (dat_o[NUM_IRQ-1:0] == $past(enables)))
		else $error("enable word read back wrong value");

	enable_hold_a: assert property (
		disable iff (rst_i)
		!(wr_take && hit_enable && sel_i[0]) |=> $stable(enables))
		else $error("enables changed without a write");

	flag_write_a: assert property (
		disable iff (rst_i)
		(wr_take && hit_flag && !tick_256hz_i) |=> (flags == $past(flags)))
		else $error("write changed flag word");

	flag_clear_a: assert property (
		disable iff (rst_i)
		(rd_take && hit_flag && !tick_256hz_i) |=>
			(flags == FLAG_RST && dat_o[2:0] == $past(flags)))
		else $error("flag read did not return and clear flags");

	irq_gate_a: assert property (
		disable iff (rst_i)
		(wr_take && hit_enable && sel_i[0] && !tick_256hz_i &&
			((dat_i[NUM_IRQ-1:0] & flags) == 3'h0)) |=> !irq_o)
		else $error("masked flag raised request");

	irq_raise_a: assert property (
		disable iff (rst_i)
		(wr_take && hit_enable && sel_i[0] && dat_i[F_8HZ] && flags[F_8HZ] &&
			!(rd_take && hit_flag)) |=> irq_o)
		else $error("enabled flag did not raise request");

	restart_a: assert property (
		disable iff (rst_i)
		restart ##1 (tick_256hz_i && !restart) |=> (count == CNT_ONE))
		else $error("restart did not clear and resume counting");

	restart_zero_a: assert property (
		disable iff (rst_i)
		(wr_take && hit_control && !dat_i[RESTART_BIT] && !tick_256hz_i) |=>
			$stable(count))
		else $error("writing zero to restart altered counter");

	control_read_a: assert property (
		disable iff (rst_i)
		(rd_take && hit_control) |=> (dat_o == DAT_ZERO))
		else $error("control word did not read as zero");

	unused_bits_a: assert property (
		disable iff (rst_i)
		(rd_take && (hit_enable || hit_flag)) |=> (dat_o[DAT_W-1:3] == '0))
		else $error("unused bits read nonzero");

	ack_pulse_a: assert property (
		disable iff (rst_i)
		(cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
		else $error("ack not a single cycle pulse");

	irq_hold_a: assert property (
		disable iff (rst_i)
		(irq_o && !(rd_take && hit_flag) && !(wr_take && hit_enable)) |=> irq_o)
		else $error("request dropped while flag and enable stood");

	irq_clear_a: assert property (
		disable iff (rst_i)
		(rd_take && hit_flag && !tick_256hz_i) |=> !irq_o)
		else $error("request stayed after flag read");

	restart_clear_a: assert property (
		disable iff (rst_i)
		restart |=> (count == CNT_RST))
		else $error("restart did not clear counter");

	restart_flag_a: assert property (
		disable iff (rst_i)
		restart |=> (flags == $past(flags)))
		else $error("restart changed the flags");

	flag_32hz_a: assert property (
		disable iff (rst_i)
		(tick_256hz_i && !restart && count[2:0] == 3'h7) |=> flags[F_32HZ])
		else $error("32 Hz falling edge did not set flag");

	quiet_32hz_a: assert property (
		disable iff (rst_i)
		(!flags[F_32HZ] && !(tick_256hz_i && !restart && count[2:0] == 3'h7)) |=>
			!flags[F_32HZ])
		else $error("32 Hz flag set without falling edge");

	quiet_8hz_a: assert property (
		disable iff (rst_i)
		(!flags[F_8HZ] && !(tick_256hz_i && !restart && count[4:0] == 5'h1f)) |=>
			!flags[F_8HZ])
		else $error("8 Hz flag set without falling edge");

	quiet_2hz_a: assert property (
		disable iff (rst_i)
		(!flags[F_2HZ] && !(tick_256hz_i && !restart && count == 7'h7f)) |=>
			!flags[F_2HZ])
		else $error("2 Hz flag set without falling edge");

	flag_sticky_a: assert property (
		disable iff (rst_i)
		!(rd_take && hit_flag) |=> ((flags & $past(flags)) == $past(flags)))
		else $error("flag cleared without a flag read");

	wrap_flags_a: assert property (
		disable iff (rst_i)
		(tick_256hz_i && !restart && count == 7'h7f) |=> (flags == 3'h7))
		else $error("counter wrap did not set all flags");

	ack_idle_a: assert property (
		disable iff (rst_i)
		!(cyc_i && stb_i) |=> !ack_o)
		else $error("ack without a request");

	read_idle_a: assert property (
		disable iff (rst_i)
		!rd_take |=> (dat_o == DAT_ZERO))
		else $error("read data not zero outside a read");

	unmapped_read_a: assert property (
		disable iff (rst_i)
		(rd_take && !hit_stage && !hit_enable && !hit_flag) |=> (dat_o == DAT_ZERO))
		else $error("unstored word read nonzero");

	reset_read_a: assert property (
		rst_i |=> (dat_o == DAT_ZERO && count[STAGE_MSB:STAGE_LSB] == 4'h0))
		else $error("reset left read data or stages nonzero");

endmodule

// ===== verif/clock_timer_interrupts_tb.sv
// Self-checking bench for the clock timer and its three interrupts
`timescale 1ns/100ps

module clock_timer_interrupts_tb;
	import clock_timer_pkg::*;

	logic             clk_i;
	logic             rst_i;
	logic             tick_256hz_i;
	logic [ADR_W-1:0] adr_i;
	logic [DAT_W-1:0] dat_i;
	logic [SEL_W-1:0] sel_i;
	logic             we_i;
	logic             cyc_i;
	logic             stb_i;
	logic [DAT_W-1:0] dat_o;
	logic             ack_o;
	logic             irq_o;
	int               mismatches;
	int               comparisons;
	int               cycles;

	localparam logic [ADR_W-1:0] A_STG = {2'b00, IDX_STAGE, 2'b00};
	localparam logic [ADR_W-1:0] A_EN  = {2'b00, IDX_ENABLE, 2'b00};
	localparam logic [ADR_W-1:0] A_FLG = {2'b00, IDX_FLAG, 2'b00};
	localparam logic [ADR_W-1:0] A_CTL = {2'b00, IDX_CONTROL, 2'b00};
	localparam logic [ADR_W-1:0] A_BAD = 12'h000;

	clock_timer_interrupts u_clock_timer_interrupts (
		.clk_i(clk_i), .rst_i(rst_i), .tick_256hz_i(tick_256hz_i),
		.adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
		.irq_o(irq_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task automatic tally_and_finish();
		if (mismatches == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk_dat(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t read %h expected %h", $time, got, exp);
		end
	endtask

	// Sampled mid-cycle so the register updates of the last edge have landed
	task automatic chk_irq(input logic exp);
		@(negedge clk_i);
		comparisons++;
		if (irq_o !== exp) begin
			mismatches++;
			$display("MISMATCH %0t irq %b expected %b", $time, irq_o, exp);
		end
	endtask

	// No fixed latency assumed: the bench timeout bounds a missing ack
	task automatic wb(input logic we, input logic [ADR_W-1:0] a,
			input logic [DAT_W-1:0] d, output logic [DAT_W-1:0] q);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= we;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask

	task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
		logic [DAT_W-1:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] exp);
		logic [DAT_W-1:0] q;
		wb(1'b0, a, 32'h0000_0000, q);
		chk_dat(q, exp);
	endtask

	// Ticks run faster than 256 Hz to keep the run short
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk_i);
			tick_256hz_i <= 1'b1;
			@(posedge clk_i);
			tick_256hz_i <= 1'b0;
		end
		repeat (2) @(posedge clk_i);
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			$display("MISMATCH %0t bench timeout", $time);
			tally_and_finish();
		end
	end

	initial begin
		mismatches = 0;
		comparisons = 0;
		cycles = 0;
		rst_i = 1'b1;
		tick_256hz_i = 1'b0;
		adr_i = 12'h000;
		dat_i = 32'h0000_0000;
		sel_i = 4'h0;
		we_i = 1'b0;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(A_STG, 32'h0);
		rd(A_EN, 32'h0);
		rd(A_FLG, 32'h0);
		rd(A_CTL, 32'h0);
		rd(A_BAD, 32'h0);
		chk_irq(1'b0);
		wr(A_STG, 32'hf);
		rd(A_STG, 32'h0);
		ticks(8);
		rd(A_STG, 32'h1);
		rd(A_FLG, 32'h1);
		rd(A_FLG, 32'h0);
		chk_irq(1'b0);
		wr(A_EN, 32'hf);
		rd(A_EN, 32'h7);
		wr(A_FLG, 32'h7);
		rd(A_FLG, 32'h0);
		wr(A_CTL, 32'h4);
		rd(A_STG, 32'h0);
		ticks(32);
		rd(A_STG, 32'h4);
		chk_irq(1'b1);
		// Enabled flags are read only while no tick is due
		rd(A_FLG, 32'h3);
		chk_irq(1'b0);
		wr(A_EN, 32'h0);
		ticks(96);
		rd(A_STG, 32'h0);
		wr(A_EN, 32'h0);
		chk_irq(1'b0);
		wr(A_EN, 32'h4);
		chk_irq(1'b1);
		rd(A_FLG, 32'h7);
		chk_irq(1'b0);
		ticks(8);
		wr(A_CTL, 32'h3);
		rd(A_STG, 32'h1);
		rd(A_CTL, 32'h0);
		// A tick held across the restart is lost only in the restart cycle; the held tick in the next cycle counts from zero
		tick_256hz_i <= 1'b1;
		wr(A_CTL, 32'h4);
		tick_256hz_i <= 1'b0;
		rd(A_STG, 32'h0);
		tally_and_finish();
	end
endmodule
